/* File: nvsl_pkg.sv */
// nvsl_pkg: constants shared by the two-wire serial byte memory slave
// assumes: included before the link and the top module
package nvsl_pkg;
  // ==========================================================
  // array geometry
  localparam int          NVSL_DEPTH      = 2048;
  localparam int          NVSL_ADDR_W     = 11;
  localparam int          NVSL_ROW_W      = 8;
  localparam int          NVSL_SEG_W      = 3;
  localparam int          NVSL_DATA_W     = 8;
  // ==========================================================
  // address byte fields
  localparam int          NVSL_TYPE_HI    = 7;
  localparam int          NVSL_TYPE_LO    = 4;
  localparam int          NVSL_SEG_HI     = 3;
  localparam int          NVSL_SEG_LO     = 1;
  localparam int          NVSL_RW_BIT     = 0;
  // device type code: value arbitrary
  localparam logic [3:0]  NVSL_TYPE_CODE  = 4'h5;
  // ==========================================================
  // bit counter: eight data bits then acknowledge slot
  localparam logic [3:0]  NVSL_BIT_LAST   = 4'h7;
  localparam logic [3:0]  NVSL_BIT_ACK    = 4'h8;
  localparam logic [10:0] NVSL_ADDR_RST   = 11'h000;
  localparam logic [7:0]  NVSL_BYTE_RST   = 8'h00;

  // protocol phase
  typedef enum logic [2:0] {
    NVSL_IDLE  = 3'b000,
    NVSL_DEVA  = 3'b001,
    NVSL_ROW   = 3'b011,
    NVSL_WDATA = 3'b010,
    NVSL_RDATA = 3'b110,
    NVSL_SKIP  = 3'b111
  } nvsl_phase_t;
endpackage : nvsl_pkg

/* File: nvsl_link_if.sv */
// nvsl_link_if: byte-level transfer between the serial engine and the array
// assumes: both ends on the serial clock domain
`timescale 1ns/100ps
`default_nettype none
interface nvsl_link_if;
  logic        wr_en;
  logic [10:0] wr_addr;
  logic [7:0]  wr_data;
  logic [10:0] rd_addr;
  logic [7:0]  rd_data;
  modport engine (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
  modport array  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface : nvsl_link_if
`default_nettype wire

/* File: nvsl_array.sv */
// nvsl_array: 2048 x 8 storage, written on the serial clock
// assumes: link from the serial engine; asynchronous read port
`timescale 1ns/100ps
`default_nettype none
module nvsl_array
  import nvsl_pkg::*;
#(
  parameter int DEPTH = NVSL_DEPTH
) (
  input  wire logic  clk_i,
  nvsl_link_if.array link
);
  import nvsl_pkg::*;

  logic [NVSL_DATA_W-1:0] mem [DEPTH];

  // ==========================================================
  // write port, read is combinational
  always_ff @(posedge clk_i) begin
    if (link.wr_en) begin
      mem[link.wr_addr] <= link.wr_data;
    end
  end
  assign link.rd_data = mem[link.rd_addr];
endmodule : nvsl_array
`default_nettype wire

/* File: nvsl_slave.sv */
// nvsl_slave: two-wire serial slave for a 2048 x 8 nonvolatile byte memory
// assumes: master drives scl; sda is open drain with external pull-up;
// reset_i is the on-chip power-on reset in the mclk_i domain
`timescale 1ns/100ps
`default_nettype none
module nvsl_slave
  import nvsl_pkg::*;
#(
  parameter int DEPTH = NVSL_DEPTH
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic wp_i,
  output logic      busy_o
);
  import nvsl_pkg::*;

  // ==========================================================
  // power-on reset carried into the serial clock domain
  logic [1:0] rst_sync;
  always_ff @(posedge scl_i or posedge reset_i) begin
    if (reset_i) begin
      rst_sync <= 2'b11;
    end else begin
      rst_sync <= {rst_sync[0], 1'b0};
    end
  end
  logic srst;
  assign srst = rst_sync[1];

  // ==========================================================
  // start and stop detection: sda edges while scl high
  logic start_tgl;
  logic stop_tgl;
  always_ff @(negedge sda_i or posedge reset_i) begin
    if (reset_i) begin
      start_tgl <= 1'b0;
    end else if (scl_i) begin
      start_tgl <= ~start_tgl;
    end
  end
  always_ff @(posedge sda_i or posedge reset_i) begin
    if (reset_i) begin
      stop_tgl <= 1'b0;
    end else if (scl_i) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // seen-state on scl rise; differing toggle means a condition occurred
  logic start_seen;
  logic stop_seen;
  always_ff @(posedge scl_i) begin
    start_seen <= start_tgl;
    stop_seen  <= stop_tgl;
  end
  logic got_start;
  logic got_stop;
  assign got_start = (start_seen != start_tgl);
  assign got_stop  = (stop_seen != stop_tgl);

  // ==========================================================
  // write protect: level pin, two flops on the serial clock
  logic [1:0] wp_sync;
  always_ff @(posedge scl_i) begin
    if (srst) begin
      wp_sync <= 2'b00;
    end else begin
      wp_sync <= {wp_sync[0], wp_i};
    end
  end
  logic wp_on;
  assign wp_on = wp_sync[1];

  // ==========================================================
  // serial engine state
  typedef struct packed {
    nvsl_phase_t     phase;
    logic [3:0]      bitc;
    logic [7:0]      shreg;
    logic [10:0]     addr;
    logic            rw;
    logic            ack_ok;
    logic            wr_en;
    logic [7:0]      wr_data;
    logic [10:0]     wr_addr;
    logic            active;  // registered not-idle flag, safe to hand over
  } nvsl_rise_t;
  nvsl_rise_t r;
  nvsl_rise_t next_r;

  nvsl_link_if link ();
  nvsl_array #(.DEPTH(DEPTH)) u_array (
    .clk_i (scl_i),
    .link  (link)
  );
  assign link.wr_en   = r.wr_en;
  assign link.wr_addr = r.wr_addr;
  assign link.wr_data = r.wr_data;
  assign link.rd_addr = r.addr;

  logic [7:0] rx_byte;
  assign rx_byte = {r.shreg[6:0], sda_i};

  // rising-edge engine: sampling, decode, address and writes
  always_comb begin
    next_r       = r;
    next_r.wr_en = 1'b0;
    if (got_start) begin
      // a start aborts anything; this rise is the first address bit
      next_r.phase = NVSL_DEVA;
      next_r.bitc  = 4'h1;
      next_r.shreg = {7'h00, sda_i};
    end else if (got_stop) begin
      next_r.phase = NVSL_IDLE;
    end else if (r.phase != NVSL_IDLE) begin
      if (r.bitc == NVSL_BIT_ACK) begin
        // ninth clock: acknowledge slot
        next_r.bitc = 4'h0;
        if (r.phase == NVSL_RDATA) begin
          if (sda_i) begin
            next_r.phase = NVSL_SKIP;
          end
        end else if (!r.ack_ok) begin
          next_r.phase = NVSL_SKIP;
        end
      end else begin
        next_r.shreg = rx_byte;
        next_r.bitc  = r.bitc + 4'h1;
        if (r.bitc == NVSL_BIT_LAST) begin
          unique case (r.phase)
            NVSL_DEVA: begin
              next_r.ack_ok = (rx_byte[NVSL_TYPE_HI:NVSL_TYPE_LO] == NVSL_TYPE_CODE);
              next_r.rw     = rx_byte[NVSL_RW_BIT];
              // segment replaces high bits, row bits kept
              next_r.addr   = {rx_byte[NVSL_SEG_HI:NVSL_SEG_LO],
                               r.addr[NVSL_ROW_W-1:0]};
              if (rx_byte[NVSL_TYPE_HI:NVSL_TYPE_LO] == NVSL_TYPE_CODE) begin
                next_r.phase = rx_byte[NVSL_RW_BIT] ? NVSL_RDATA : NVSL_ROW;
              end else begin
                next_r.phase = NVSL_SKIP;
              end
            end
            NVSL_ROW: begin
              next_r.addr   = {r.addr[NVSL_ADDR_W-1:NVSL_ROW_W], rx_byte};
              next_r.ack_ok = 1'b1;
              next_r.phase  = NVSL_WDATA;
            end
            NVSL_WDATA: begin
              next_r.ack_ok = !wp_on;
              if (!wp_on) begin
                next_r.wr_en   = 1'b1;
                next_r.wr_data = rx_byte;
                next_r.wr_addr = r.addr;
                next_r.addr    = r.addr + 11'h001;
              end
            end
            NVSL_RDATA: begin
              next_r.addr   = r.addr + 11'h001;
              // the master owns the slot after a data byte we sent
              next_r.ack_ok = 1'b0;
            end
            NVSL_SKIP: begin
              next_r.phase = NVSL_SKIP;
            end
            default: begin
              next_r.phase = NVSL_IDLE;
            end
          endcase
        end
      end
    end
    // one flop carries activity out; a multi-bit phase compare could glitch
    next_r.active = (next_r.phase != NVSL_IDLE);
  end

  always_ff @(posedge scl_i) begin
    if (srst) begin
      r.phase   <= NVSL_IDLE;
      r.bitc    <= 4'h0;
      r.shreg   <= NVSL_BYTE_RST;
      r.addr    <= NVSL_ADDR_RST;
      r.rw      <= 1'b0;
      r.ack_ok  <= 1'b0;
      r.wr_en   <= 1'b0;
      r.wr_data <= NVSL_BYTE_RST;
      r.wr_addr <= NVSL_ADDR_RST;
      r.active  <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // falling-edge driver: updates sda only after scl falls
  typedef struct packed {
    logic       pull;
    logic [7:0] tx;
  } nvsl_fall_t;
  nvsl_fall_t f;
  nvsl_fall_t next_f;

  always_comb begin
    next_f      = f;
    next_f.pull = 1'b0;
    if (r.phase != NVSL_IDLE && r.phase != NVSL_SKIP) begin
      if (r.bitc == NVSL_BIT_ACK) begin
        // ack slot: pulled low only for bytes this slave received and took,
        // the address byte of a read included; clear after a read data byte
        next_f.pull = r.ack_ok;
      end else if (r.phase == NVSL_RDATA) begin
        if (r.bitc == 4'h0) begin
          next_f.tx   = {link.rd_data[6:0], 1'b0};
          next_f.pull = !link.rd_data[7];
        end else begin
          next_f.tx   = {f.tx[6:0], 1'b0};
          next_f.pull = !f.tx[7];
        end
      end
    end
  end

  always_ff @(negedge scl_i) begin
    if (srst) begin
      f.pull <= 1'b0;
      f.tx   <= NVSL_BYTE_RST;
    end else begin
      f <= next_f;
    end
  end

  // only ever pull low or release the line
  assign sda_o    = 1'b0;
  assign sda_oe_o = f.pull;

  // ==========================================================
  // system clock side: activity passes two flops, start and stop three each
  // scl stands high after a stop, so the serial engine cannot see it
  // until the next start; the stop toggle clears busy here instead
  typedef struct packed {
    logic [1:0] act_sync;
    logic [2:0] start_sync;
    logic [2:0] stop_sync;
    logic       stopped;
    logic       busy;
  } nvsl_sys_t;
  nvsl_sys_t sys;
  nvsl_sys_t next_sys;
  logic      start_evt;
  logic      stop_evt;

  // a toggle that moved between the last two flops marks a condition
  assign start_evt = sys.start_sync[2] ^ sys.start_sync[1];
  assign stop_evt  = sys.stop_sync[2] ^ sys.stop_sync[1];

  // busy is activity not yet closed by a stop
  always_comb begin
    next_sys            = sys;
    next_sys.act_sync   = {sys.act_sync[0], r.active};
    next_sys.start_sync = {sys.start_sync[1:0], start_tgl};
    next_sys.stop_sync  = {sys.stop_sync[1:0], stop_tgl};
    if (start_evt) begin
      next_sys.stopped = 1'b0; // a new transaction wins over an old stop
    end else if (stop_evt) begin
      next_sys.stopped = 1'b1;
    end
    next_sys.busy = sys.act_sync[1] && !sys.stopped;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end
  assign busy_o = sys.busy;
endmodule : nvsl_slave
`default_nettype wire

/* File: nvsl_slave_props.sv */
// nvsl_slave_props: port checks for the serial slave
// assumes: bound to nvsl_slave; mclk_i samples the serial side
`timescale 1ns/100ps
`default_nettype none
module nvsl_slave_props (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic sda_o,
  input  wire logic sda_oe_o,
  input  wire logic wp_i,
  input  wire logic busy_o
);
  // ========================================
  // steps of a transfer
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  sequence start_seen;
    scl_i && $fell(sda_i);
  endsequence
  sequence idle_run;
    !busy_o [*8];
  endsequence
  // line only pulled low, changed in the low phase
  AST_OPEN_DRAIN: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  AST_OE_ON_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda drive moved with scl high");
  AST_OE_STEADY: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("sda drive unstable");
  AST_OE_AT_FALL: assert property ($rose(sda_oe_o) |-> $fell(scl_i))
    else $error("drive not at scl fall");
  AST_OE_HOLDS: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("drive too short");
  AST_BUSY_WITH_ACK: assert property ($rose(sda_oe_o) |-> ##[0:8] busy_o)
    else $error("drive while idle");
  AST_IDLE_QUIET: assert property (idle_run |-> !sda_oe_o)
    else $error("idle slave drives sda");
  AST_START_BUSY: assert property (start_seen |-> ##[1:60] busy_o)
    else $error("start not taken");
endmodule : nvsl_slave_props
bind nvsl_slave nvsl_slave_props nvsl_slave_props_inst (.mclk_i, .reset_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .wp_i, .busy_o);
`default_nettype wire

/* File: nvsl_master_model.sv */
// nvsl_master_model: bus master making scl and pulling sda low
// assumes: sda_i is the resolved wire with pull-up
`timescale 1ns/100ps
`default_nettype none
module nvsl_master_model (
  output var logic  scl_o,
  output var logic  sda_pull_o,
  input  wire logic sda_i
);
  // ========================================
  // idle bus: scl high, sda released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // one 160 ns clock, data set in low phase
  task automatic bit_cycle(input logic b, output logic s);
    sda_pull_o = !b;
    #40 scl_o = 1'b1;
    #40 s = sda_i;
    #40 scl_o = 1'b0;
    #40;
  endtask : bit_cycle
  // free clocks for the reset sync
  task automatic pulses(input int n);
    repeat (n) begin
      #80 scl_o = 1'b0;
      #80 scl_o = 1'b1;
    end
  endtask : pulses
  // sda falls while scl high
  task automatic start_cond();
    sda_pull_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_pull_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask : start_cond
  // sda rises while scl high, clock then stands
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_pull_o = 1'b0;
    #80;
  endtask : stop_cond
  // msb first, then ack slot released
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, nak);
  endtask : send_byte
  // eight bits in, then ack or no-ack
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, b[i]);
    end
    bit_cycle(!ack, s);
  endtask : recv_byte
endmodule : nvsl_master_model
`default_nettype wire

/* File: nvsl_slave_bench.sv */
// nvsl_slave_bench: self-checking bench for the serial slave
// assumes: master model on the wire, sda pulled up
`timescale 1ns/100ps
`default_nettype none
module nvsl_slave_bench;
  import nvsl_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wp_i = 1'b0;
  wire  scl, sda_oe, sda_o, pull, busy;
  wire  sda = !(sda_oe & !sda_o) & !pull;
  int   error_cnt = 0;
  int   checks = 0;
  int   cyc = 0;
  // ========================================
  // clock, design and master
  always #5 mclk_i = !mclk_i;
  nvsl_slave nvsl_slave_inst (.mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp_i), .busy_o(busy));
  nvsl_master_model nvsl_master_model_inst (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // byte out with expected ack, byte in with expected data
  task automatic tx(input logic [7:0] b, input logic exp_nak);
    logic nak;
    nvsl_master_model_inst.send_byte(b, nak);
    check({7'h00, nak}, {7'h00, exp_nak});
  endtask : tx
  task automatic rx(input logic ack, input logic [7:0] exp);
    logic [7:0] b;
    nvsl_master_model_inst.recv_byte(ack, b);
    check(b, exp);
  endtask : rx
  // start, address byte, and row byte for writes
  task automatic open_rd(input logic [2:0] seg);
    nvsl_master_model_inst.start_cond();
    tx({NVSL_TYPE_CODE, seg, 1'b1}, 1'b0);
  endtask : open_rd
  task automatic set_ptr(input logic [2:0] seg, input logic [7:0] row);
    nvsl_master_model_inst.start_cond();
    tx({NVSL_TYPE_CODE, seg, 1'b0}, 1'b0);
    tx(row, 1'b0);
  endtask : set_ptr
  // ========================================
  // scenarios
  task automatic t_write_read();
    set_ptr(3'h3, 8'h10);
    tx(8'ha5, 1'b0);
    tx(8'h3c, 1'b0);
    set_ptr(3'h3, 8'h10);
    open_rd(3'h3);
    rx(1'b1, 8'ha5);
    rx(1'b0, 8'h3c);
    nvsl_master_model_inst.stop_cond();
    check({7'h00, busy}, 8'h00);
    $display("write_read done");
  endtask : t_write_read
  task automatic t_wrap();
    set_ptr(3'h7, 8'hff);
    tx(8'h11, 1'b0);
    tx(8'h22, 1'b0);
    set_ptr(3'h7, 8'hff);
    open_rd(3'h7);
    rx(1'b1, 8'h11);
    rx(1'b0, 8'h22);
    check({7'h00, sda_oe}, 8'h00);
    nvsl_master_model_inst.stop_cond();
    $display("wrap done");
  endtask : t_wrap
  task automatic t_protect();
    set_ptr(3'h1, 8'h05);
    tx(8'h5a, 1'b0);
    @(negedge mclk_i) wp_i = 1'b1;
    set_ptr(3'h1, 8'h05);
    tx(8'h77, 1'b1);
    check({7'h00, busy}, 8'h01);
    nvsl_master_model_inst.stop_cond();
    @(negedge mclk_i) wp_i = 1'b0;
    open_rd(3'h1);
    rx(1'b0, 8'h5a);
    set_ptr(3'h1, 8'h10);
    open_rd(3'h3);
    rx(1'b0, 8'ha5);
    nvsl_master_model_inst.stop_cond();
    $display("protect done");
  endtask : t_protect
  task automatic t_bad_type();
    nvsl_master_model_inst.start_cond();
    tx({4'h3, 3'h0, 1'b0}, 1'b1);
    nvsl_master_model_inst.stop_cond();
    $display("bad_type done");
  endtask : t_bad_type
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // reset with scl running, then the scenarios
  initial begin
    repeat (4) @(negedge mclk_i);
    nvsl_master_model_inst.pulses(3);
    check({6'h00, busy, sda_oe}, 8'h00);
    @(negedge mclk_i) reset_i = 1'b0;
    nvsl_master_model_inst.pulses(3);
    t_write_read();
    t_wrap();
    t_protect();
    t_bad_type();
    complete_run();
  end
endmodule : nvsl_slave_bench
`default_nettype wire
